// ### rtl/rsx_pkg.sv
// Constants, encodings and register map of the rotate/set/sleep execution block
package rsx_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DADDR_W = 12;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0c;
  localparam logic [7:0] OFF_INDEX = 8'h10;
  localparam logic [7:0] OFF_INSTR = 8'h14;
  localparam logic [7:0] OFF_POWER = 8'h18;
  localparam logic [7:0] OFF_MADDR = 8'h1c;
  localparam logic [7:0] OFF_MDATA = 8'h20;
  localparam logic [7:0] OFF_WDT = 8'h24;

  // Control register fields
  localparam int unsigned CTRL_EXT_EN = 0;
  localparam int unsigned CTRL_WDT_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status register fields
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;

  // Instruction register fields
  localparam int unsigned IN_F_LSB = 0;
  localparam int unsigned IN_D = 8;
  localparam int unsigned IN_A = 9;
  localparam int unsigned IN_OP_LSB = 10;
  localparam logic [12:0] INSTR_RST = 13'h0000;

  // Power register fields
  localparam int unsigned PW_TO = 0;
  localparam int unsigned PW_PD = 1;
  localparam int unsigned PW_SLEEP = 2;
  localparam int unsigned PW_WAKE = 0;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;

  // Data addressing
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] SET_VALUE = 8'hff;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_RRC = 3'h1,
    OP_RRN = 3'h2,
    OP_SET = 3'h3,
    OP_SUBB = 3'h4,
    OP_SLEEP = 3'h5
  } rsx_op_e;

  typedef enum logic {
    PS_RUN = 1'b0,
    PS_SLEEP = 1'b1
  } rsx_pstate_e;

endpackage : rsx_pkg

// ### rtl/rsx_alu_if.sv
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ns
interface rsx_alu_if;
  import rsx_pkg::*;
  rsx_op_e op;
  logic [7:0] opnd;
  logic [7:0] acc;
  logic [4:0] stat_in;
  logic [7:0] result;
  logic [4:0] stat_out;
  modport core (output op, opnd, acc, stat_in, input result, stat_out);
  modport alu (input op, opnd, acc, stat_in, output result, stat_out);
endinterface : rsx_alu_if

// ### rtl/rsx_alu.sv
// Rotate, set and subtract-with-borrow arithmetic with flag update
`timescale 1ns/1ns
module rsx_alu import rsx_pkg::*; (
  rsx_alu_if.alu bus
);

  wire cin = bus.stat_in[ST_C];
  // RULE1 - Rotate via carry
  wire [7:0] rrc_w = {cin, bus.opnd[7:1]};
  // RULE2 - Rotate without carry
  wire [7:0] rrn_w = {bus.opnd[0], bus.opnd[7:1]};
  // RULE12 - Subtract with borrow
  wire [8:0] sub_w = {1'b0, bus.acc} + {1'b0, ~bus.opnd} + {8'h00, cin};
  wire [4:0] sub_lo_w = {1'b0, bus.acc[3:0]} + {1'b0, ~bus.opnd[3:0]} + {4'h0, cin};
  wire sub_ov_w = (bus.acc[7] != bus.opnd[7]) && (sub_w[7] != bus.acc[7]);

  wire is_rrc = (bus.op == OP_RRC);
  wire is_rrn = (bus.op == OP_RRN);
  wire is_sub = (bus.op == OP_SUBB);
  wire is_set = (bus.op == OP_SET);

  assign bus.result = is_rrc ? rrc_w :
                      is_rrn ? rrn_w :
                      is_sub ? sub_w[7:0] :
                      is_set ? SET_VALUE : bus.opnd;

  // RULE11 - N and Z from result
  wire nz_upd = is_rrc | is_rrn | is_sub;
  wire res_z = (bus.result == 8'h00);

  assign bus.stat_out[ST_N] = nz_upd ? bus.result[7] : bus.stat_in[ST_N];
  assign bus.stat_out[ST_Z] = nz_upd ? res_z : bus.stat_in[ST_Z];
  assign bus.stat_out[ST_C] = is_rrc ? bus.opnd[0] : is_sub ? sub_w[8] : bus.stat_in[ST_C];
  assign bus.stat_out[ST_DC] = is_sub ? sub_lo_w[4] : bus.stat_in[ST_DC];
  assign bus.stat_out[ST_OV] = is_sub ? sub_ov_w : bus.stat_in[ST_OV];

endmodule : rsx_alu

// ### rtl/rsx_addr.sv
// Operand address resolution: access bank, bank pointer, indexed literal offset
`timescale 1ns/1ns
module rsx_addr import rsx_pkg::*; (
  input wire logic [7:0] f_addr,
  input wire logic bank_sel,
  input wire logic ext_en,
  input wire logic [3:0] bank_pointer,
  input wire logic [DADDR_W-1:0] index_base,
  output logic [DADDR_W-1:0] eff_addr,
  output logic indexed
);

  // RULE7 - Indexed literal offset
  assign indexed = ext_en && !bank_sel && (f_addr <= LIT_OFFSET_MAX);
  wire [DADDR_W-1:0] idx_addr = index_base + {4'h0, f_addr};
  // RULE5 - Fixed access bank
  wire [3:0] acc_bank = (f_addr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
  // RULE6 - Bank pointer select
  wire [3:0] hi_bank = bank_sel ? bank_pointer : acc_bank;

  assign eff_addr = indexed ? idx_addr : {hi_bank, f_addr};

endmodule : rsx_addr

// ### rtl/rsx_core.sv
// APB-controlled execution core for rotate, set, subtract-with-borrow and sleep
// Overview of operation
// RULE1 - Rotate right, bit0 to carry, carry to bit7
// RULE2 - Rotate right, bit0 to bit7, carry kept
// RULE3 - Destination bit picks accumulator or memory
// RULE4 - Set byte writes FFh, flags unchanged
// RULE5 - Access bit zero uses fixed access bank
// RULE6 - Access bit one uses bank pointer
// RULE7 - Extended mode, low addresses use indexed offset
// RULE8 - Sleep halts oscillator, lowest power
// RULE9 - Sleep clears PD, sets TO, clears watchdog
// RULE10 - Watchdog wake clears timeout flag
// RULE11 - Rotates update N and Z flags
// RULE12 - Subtract with borrow, full flags, destination routed
`timescale 1ns/1ns
module rsx_core import rsx_pkg::*; #(
  parameter int DMEM_DEPTH = 256,
  parameter int WDT_POST = 128,
  parameter int WDT_BITS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic osc_run,
  output logic asleep
);

  localparam int IDXW = $clog2(DMEM_DEPTH);
  localparam int POSTW = $clog2(WDT_POST);
  localparam logic [POSTW-1:0] POST_LAST = POSTW'(WDT_POST - 1);

  function automatic logic [DATA_W-1:0] merge_strb(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  logic [1:0] ctrl_q;
  logic [7:0] acc_q;
  logic [4:0] status_q;
  logic [3:0] bank_q;
  logic [DADDR_W-1:0] index_q;
  logic [12:0] instr_q;
  logic to_q;
  logic pd_q;
  rsx_pstate_e ps_q;
  logic [DADDR_W-1:0] maddr_q;
  logic [7:0] mem_q [DMEM_DEPTH];
  logic [WDT_BITS-1:0] wdt_q;
  logic [POSTW-1:0] post_q;
  logic [DATA_W-1:0] prdata_q;

  // Bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire sel_ctrl = (paddr == OFF_CTRL);
  wire sel_acc = (paddr == OFF_ACC);
  wire sel_status = (paddr == OFF_STATUS);
  wire sel_bank = (paddr == OFF_BANK);
  wire sel_index = (paddr == OFF_INDEX);
  wire sel_instr = (paddr == OFF_INSTR);
  wire sel_power = (paddr == OFF_POWER);
  wire sel_maddr = (paddr == OFF_MADDR);
  wire sel_mdata = (paddr == OFF_MDATA);
  wire sel_wdt = (paddr == OFF_WDT);
  wire hit = sel_ctrl | sel_acc | sel_status | sel_bank | sel_index | sel_instr
             | sel_power | sel_maddr | sel_mdata | sel_wdt;

  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_q;
  assign osc_run = (ps_q == PS_RUN);
  assign asleep = (ps_q == PS_SLEEP);

  // Merged write values
  wire [DATA_W-1:0] ctrl_m = merge_strb({30'h0, ctrl_q}, pwdata, pstrb);
  wire [DATA_W-1:0] acc_m = merge_strb({24'h0, acc_q}, pwdata, pstrb);
  wire [DATA_W-1:0] status_m = merge_strb({27'h0, status_q}, pwdata, pstrb);
  wire [DATA_W-1:0] bank_m = merge_strb({28'h0, bank_q}, pwdata, pstrb);
  wire [DATA_W-1:0] index_m = merge_strb({20'h0, index_q}, pwdata, pstrb);
  wire [DATA_W-1:0] instr_m = merge_strb({19'h0, instr_q}, pwdata, pstrb);
  wire [DATA_W-1:0] maddr_m = merge_strb({20'h0, maddr_q}, pwdata, pstrb);

  // Instruction issue, refused while asleep
  wire instr_wr = wr & sel_instr & (|pstrb[1:0]);
  wire fire = instr_wr & (ps_q == PS_RUN);
  wire [7:0] f_field = instr_m[IN_F_LSB +: 8];
  wire d_field = instr_m[IN_D];
  wire a_field = instr_m[IN_A];
  rsx_op_e op_w;
  assign op_w = rsx_op_e'(instr_m[IN_OP_LSB +: 3]);
  wire is_rot = (op_w == OP_RRC) | (op_w == OP_RRN);
  wire is_sub = (op_w == OP_SUBB);
  wire is_set = (op_w == OP_SET);
  wire is_sleep = (op_w == OP_SLEEP);

  // Operand address
  logic [DADDR_W-1:0] eff_addr;
  logic indexed;
  rsx_addr u_addr (
    .f_addr(f_field),
    .bank_sel(a_field),
    .ext_en(ctrl_q[CTRL_EXT_EN]),
    .bank_pointer(bank_q),
    .index_base(index_q),
    .eff_addr(eff_addr),
    .indexed(indexed)
  );
  wire [IDXW-1:0] eff_idx = eff_addr[IDXW-1:0];
  wire [IDXW-1:0] maddr_idx = maddr_q[IDXW-1:0];

  // Arithmetic unit
  rsx_alu_if alu_bus ();
  assign alu_bus.op = op_w;
  assign alu_bus.opnd = mem_q[eff_idx];
  assign alu_bus.acc = acc_q;
  assign alu_bus.stat_in = status_q;
  rsx_alu u_alu (
    .bus(alu_bus)
  );
  wire [7:0] res_w = alu_bus.result;

  // RULE3 - Destination routing
  wire to_acc = fire & (is_rot | is_sub) & ~d_field;
  wire to_mem = fire & (((is_rot | is_sub) & d_field) | is_set);
  wire stat_upd = fire & (is_rot | is_sub);
  wire mem_apb = wr & sel_mdata & pstrb[0];
  wire mem_we = to_mem | mem_apb;
  wire [IDXW-1:0] mem_widx = to_mem ? eff_idx : maddr_idx;
  wire [7:0] mem_wval = to_mem ? res_w : pwdata[7:0];

  // Watchdog timing
  wire wdt_en = ctrl_q[CTRL_WDT_EN];
  wire wdt_tick = wdt_en & (post_q == POST_LAST);
  wire wdt_expire = wdt_tick & (wdt_q == {WDT_BITS{1'b1}});
  wire sleep_fire = fire & is_sleep;
  wire wdt_clr = sleep_fire | (wr & sel_wdt);
  wire wake_req = wr & sel_power & pstrb[0] & pwdata[PW_WAKE];
  wire wdt_wake = (ps_q == PS_SLEEP) & wdt_expire;

  // Read data
  wire [DATA_W-1:0] rd_w =
      ({DATA_W{sel_ctrl}} & {30'h0, ctrl_q}) |
      ({DATA_W{sel_acc}} & {24'h0, acc_q}) |
      ({DATA_W{sel_status}} & {27'h0, status_q}) |
      ({DATA_W{sel_bank}} & {28'h0, bank_q}) |
      ({DATA_W{sel_index}} & {20'h0, index_q}) |
      ({DATA_W{sel_instr}} & {19'h0, instr_q}) |
      ({DATA_W{sel_power}} & {29'h0, asleep, pd_q, to_q}) |
      ({DATA_W{sel_maddr}} & {20'h0, maddr_q}) |
      ({DATA_W{sel_mdata}} & {24'h0, mem_q[maddr_idx]}) |
      ({DATA_W{sel_wdt}} & DATA_W'(wdt_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      bank_q <= 4'h0;
      index_q <= 12'h000;
      maddr_q <= 12'h000;
      instr_q <= INSTR_RST;
    end else begin
      if (wr & sel_ctrl) ctrl_q <= ctrl_m[1:0];
      if (wr & sel_bank) bank_q <= bank_m[3:0];
      if (wr & sel_index) index_q <= index_m[DADDR_W-1:0];
      if (wr & sel_maddr) maddr_q <= maddr_m[DADDR_W-1:0];
      if (fire) instr_q <= instr_m[12:0];
    end
  end

  // RULE3 - Accumulator or status update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 8'h00;
      status_q <= STATUS_RST;
    end else begin
      if (to_acc) acc_q <= res_w;
      else if (wr & sel_acc) acc_q <= acc_m[7:0];
      if (stat_upd) status_q <= alu_bus.stat_out;
      else if (wr & sel_status) status_q <= status_m[4:0];
    end
  end

  // RULE4 - Memory write of result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DMEM_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (mem_we) begin
      mem_q[mem_widx] <= mem_wval;
    end
  end

  // RULE9 - Watchdog clear on sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= '0;
      wdt_q <= '0;
    end else if (wdt_clr) begin
      post_q <= '0;
      wdt_q <= '0;
    end else if (wdt_en) begin
      post_q <= wdt_tick ? '0 : post_q + POSTW'(1);
      if (wdt_tick) wdt_q <= wdt_q + WDT_BITS'(1);
    end
  end

  // RULE8 - Sleep state and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= PS_RUN;
    end else begin
      unique case (ps_q)
        PS_RUN: begin
          if (sleep_fire) ps_q <= PS_SLEEP;
        end
        PS_SLEEP: begin
          if (wdt_wake | wake_req) ps_q <= PS_RUN;
        end
      endcase
    end
  end

  // RULE10 - Timeout flag on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_q <= TO_RST;
      pd_q <= PD_RST;
    end else begin
      if (sleep_fire) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end else if (wdt_wake) begin
        to_q <= 1'b0;
      end
    end
  end

  a_rot_carry: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (alu_bus.op == OP_RRC) |-> (res_w == {status_q[ST_C], alu_bus.opnd[7:1]})
      && (alu_bus.stat_out[ST_C] == alu_bus.opnd[0]))
    else $error("rotate via carry result or carry wrong");

  a_rot_plain: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    fire && (op_w == OP_RRN) |=> (status_q[ST_C] == $past(status_q[ST_C]))
      && ($past(to_acc) ? acc_q == {$past(alu_bus.opnd[0]), $past(alu_bus.opnd[7:1])} : 1'b1))
    else $error("plain rotate result or carry wrong");

  a_dest_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    fire && is_rot && d_field |=> (mem_q[$past(eff_idx)] == $past(res_w))
      && (acc_q == $past(acc_q)))
    else $error("rotate result not written to memory destination");

  a_set_byte: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    fire && is_set |=> (mem_q[$past(eff_idx)] == 8'hff) && $stable(status_q))
    else $error("set byte wrong value or flags changed");

  a_access_bank: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    fire && !a_field && !indexed |-> (eff_addr[11:8] == ((f_field < 8'h60) ? 4'h0 : 4'hf)))
    else $error("access bank address wrong");

  a_bank_ptr: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    fire && a_field |-> (eff_addr == {bank_q, f_field}))
    else $error("bank pointer address wrong");

  a_indexed_mode: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    fire && ctrl_q[CTRL_EXT_EN] && !a_field && (f_field <= 8'h5f)
      |-> (eff_addr == index_q + {4'h0, f_field}))
    else $error("indexed literal offset address wrong");

  a_sleep_osc: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    sleep_fire |=> !osc_run && asleep)
    else $error("oscillator still running after sleep");

  a_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    sleep_fire |=> to_q && !pd_q && (wdt_q == '0) && (post_q == '0))
    else $error("sleep flags or watchdog not set up");

  a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    asleep && wdt_expire |=> !to_q && osc_run)
    else $error("watchdog wake did not clear timeout flag");

  a_nz_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    fire && is_rot |=> (status_q[ST_N] == $past(res_w[7]))
      && (status_q[ST_Z] == ($past(res_w) == 8'h00)))
    else $error("rotate N or Z flag wrong");

  a_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    fire && is_sub |=> (status_q[ST_Z] == ($past(res_w) == 8'h00))
      && ((8'($past(acc_q) - $past(alu_bus.opnd) - 8'(!$past(status_q[ST_C])))) == $past(res_w)))
    else $error("subtract with borrow result or zero wrong");

  a_sleep_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    asleep && instr_wr |=> $stable(acc_q) && $stable(instr_q))
    else $error("instruction executed while asleep");

  a_rrc_carry_reg: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    fire && (op_w == OP_RRC) |=> (status_q[ST_C] == $past(alu_bus.opnd[0])))
    else $error("rotate via carry did not load carry from bit 0");

  a_rot_keep_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    fire && is_rot |=> (status_q[ST_DC] == $past(status_q[ST_DC]))
      && (status_q[ST_OV] == $past(status_q[ST_OV])))
    else $error("rotate changed digit carry or overflow");

  a_sub_carry: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    fire && is_sub |=> (status_q[ST_C] == (9'($past(acc_q))
      >= 9'($past(alu_bus.opnd)) + 9'(!$past(status_q[ST_C]))))
      && (status_q[ST_N] == $past(res_w[7])))
    else $error("subtract with borrow carry or negative wrong");

  a_sub_dest: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    fire && is_sub && !d_field |=> (acc_q == $past(res_w)))
    else $error("subtract result not routed to accumulator");

  a_unmapped_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && !hit |=> $stable(ctrl_q) && $stable(acc_q) && $stable(status_q) && $stable(bank_q))
    else $error("write to unmapped address changed a register");

  a_wdt_reg_clr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_wdt |=> (wdt_q == '0) && (post_q == '0))
    else $error("watchdog register write did not clear the count");

  a_sleep_pd: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    asleep |-> !pd_q)
    else $error("powerdown flag set while asleep");

endmodule : rsx_core

// ### tb/tb_top.sv
// Self-checking testbench of the rotate/set/sleep execution core over APB
`timescale 1ns/1ns
module tb_top import rsx_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] pstrb, strb_v;
  logic pready, pslverr, osc_run, asleep, err_v;
  int error_cnt, n_tests, cyc;

  rsx_core #(.DMEM_DEPTH(4096), .WDT_POST(4), .WDT_BITS(2)) rsx_core_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_run(osc_run), .asleep(asleep)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    pstrb <= strb_v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, exp, rd_v);
  endtask : rchk

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
    wr(OFF_MADDR, {20'h0, a});
    wr(OFF_MDATA, {24'h0, v});
  endtask : mem_wr

  task automatic mem_chk(input string nm, input logic [11:0] a, input logic [7:0] v);
    wr(OFF_MADDR, {20'h0, a});
    rchk(nm, OFF_MDATA, {24'h0, v});
  endtask : mem_chk

  task automatic exec(input rsx_op_e op, input logic d, input logic a, input logic [7:0] f);
    wr(OFF_INSTR, {19'h0, op, a, d, f});
  endtask : exec

  task automatic t_reset();
    rchk("ctrl", OFF_CTRL, 32'h0);
    rchk("status", OFF_STATUS, 32'h0);
    rchk("power", OFF_POWER, 32'h3);
    chk("osc_run", 32'h1, {31'h0, osc_run});
    xfer(8'h30, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err_v});
    chk("unmapped data", 32'h0, rd_v);
    chk("pready", 32'h1, {31'h0, pready});
    xfer(8'h30, 1'b1, 32'hffff_ffff);
    chk("unmapped wr err", 32'h1, {31'h0, err_v});
    wr(OFF_ACC, 32'h5a);
    strb_v = 4'he;
    wr(OFF_ACC, 32'h11);
    strb_v = 4'hf;
    rchk("acc strobe", OFF_ACC, 32'h5a);
  endtask : t_reset

  task automatic t_rrc();
    mem_wr(12'h012, 8'he6);
    wr(OFF_STATUS, 32'h01);
    exec(OP_RRC, 1'b1, 1'b0, 8'h12);
    mem_chk("rrc mem", 12'h012, 8'hf3);
    rchk("rrc flags", OFF_STATUS, 32'h10);
    exec(OP_RRC, 1'b0, 1'b0, 8'h12);
    rchk("rrc acc", OFF_ACC, 32'h79);
    rchk("rrc flags2", OFF_STATUS, 32'h01);
    mem_chk("rrc mem kept", 12'h012, 8'hf3);
  endtask : t_rrc

  task automatic t_rrn();
    mem_wr(12'h013, 8'h01);
    wr(OFF_STATUS, 32'h0b);
    exec(OP_RRN, 1'b1, 1'b0, 8'h13);
    mem_chk("rrn mem", 12'h013, 8'h80);
    rchk("rrn flags", OFF_STATUS, 32'h1b);
    mem_wr(12'h013, 8'h00);
    exec(OP_RRN, 1'b0, 1'b0, 8'h13);
    rchk("rrn acc", OFF_ACC, 32'h00);
    rchk("rrn zero", OFF_STATUS, 32'h0f);
  endtask : t_rrn

  task automatic t_set();
    wr(OFF_BANK, 32'h3);
    wr(OFF_STATUS, 32'h15);
    mem_wr(12'h040, 8'h11);
    exec(OP_SET, 1'b0, 1'b1, 8'h40);
    mem_chk("set banked", 12'h340, 8'hff);
    mem_chk("set other bank", 12'h040, 8'h11);
    exec(OP_SET, 1'b0, 1'b0, 8'h20);
    mem_chk("set access low", 12'h020, 8'hff);
    mem_chk("set not banked", 12'h320, 8'h00);
    exec(OP_SET, 1'b0, 1'b0, 8'h80);
    mem_chk("set access high", 12'hf80, 8'hff);
    rchk("set flags", OFF_STATUS, 32'h15);
  endtask : t_set

  task automatic t_ext();
    wr(OFF_CTRL, 32'h1);
    wr(OFF_INDEX, 32'h200);
    exec(OP_SET, 1'b0, 1'b0, 8'h5f);
    mem_chk("indexed", 12'h25f, 8'hff);
    mem_chk("not direct", 12'h05f, 8'h00);
    exec(OP_SET, 1'b0, 1'b0, 8'h60);
    mem_chk("above offset", 12'hf60, 8'hff);
    exec(OP_SET, 1'b0, 1'b1, 8'h10);
    mem_chk("banked in ext", 12'h310, 8'hff);
    wr(OFF_CTRL, 32'h0);
  endtask : t_ext

  task automatic t_subb();
    wr(OFF_ACC, 32'h02);
    mem_wr(12'h030, 8'h03);
    wr(OFF_STATUS, 32'h01);
    exec(OP_SUBB, 1'b1, 1'b0, 8'h30);
    mem_chk("subb mem", 12'h030, 8'hff);
    rchk("subb flags", OFF_STATUS, 32'h10);
    mem_wr(12'h030, 8'h01);
    wr(OFF_STATUS, 32'h00);
    exec(OP_SUBB, 1'b1, 1'b0, 8'h30);
    mem_chk("subb zero", 12'h030, 8'h00);
    rchk("subb flags2", OFF_STATUS, 32'h07);
    rchk("subb acc", OFF_ACC, 32'h02);
    exec(OP_NOP, 1'b1, 1'b0, 8'h30);
    rchk("nop status", OFF_STATUS, 32'h07);
    mem_wr(12'h030, 8'h01);
    exec(OP_SUBB, 1'b0, 1'b0, 8'h30);
    rchk("subb to acc", OFF_ACC, 32'h01);
    rchk("subb flags3", OFF_STATUS, 32'h03);
    mem_chk("subb mem kept", 12'h030, 8'h01);
  endtask : t_subb

  task automatic t_sleep();
    exec(OP_SLEEP, 1'b0, 1'b0, 8'h00);
    @(posedge pclk);
    chk("asleep", 32'h1, {31'h0, asleep});
    chk("osc stopped", 32'h0, {31'h0, osc_run});
    rchk("sleep power", OFF_POWER, 32'h5);
    exec(OP_SET, 1'b0, 1'b0, 8'h50);
    mem_chk("no exec asleep", 12'h050, 8'h00);
    wr(OFF_POWER, 32'h1);
    @(posedge pclk);
    chk("woken", 32'h0, {31'h0, asleep});
    rchk("wake power", OFF_POWER, 32'h1);
  endtask : t_sleep

  task automatic t_wdt();
    int i;
    wr(OFF_CTRL, 32'h2);
    repeat (6) @(posedge pclk);
    exec(OP_SLEEP, 1'b0, 1'b0, 8'h00);
    rchk("wdt cleared", OFF_WDT, 32'h0);
    for (i = 0; i < 200 && asleep !== 1'b0; i++) @(posedge pclk);
    chk("wdt wake", 32'h0, {31'h0, asleep});
    chk("osc back", 32'h1, {31'h0, osc_run});
    rchk("wdt power", OFF_POWER, 32'h0);
    wr(OFF_WDT, 32'h0);
    rchk("wdt write clr", OFF_WDT, 32'h0);
    wr(OFF_CTRL, 32'h0);
  endtask : t_wdt

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    strb_v = 4'hf;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rrc();
    t_rrn();
    t_set();
    t_ext();
    t_subb();
    t_sleep();
    t_wdt();
    report_and_stop();
  end
endmodule : tb_top
